// File: design/sps_pkg.sv
package sps_pkg;

    // ------------------------------------------------------------
    // Clock and controller timing limits
    // ------------------------------------------------------------
    localparam int unsigned SPS_CLK_PERIOD_PS  = 10000;
    localparam int unsigned SPS_RESET_MIN_NS   = 10000;
    localparam int unsigned SPS_STEP_WIDTH_NS  = 10000;
    localparam int unsigned SPS_DIR_HOLD_NS    = 6250;
    localparam int unsigned SPS_MODE_HOLD_NS   = 5000;
    localparam int unsigned SPS_STEP_FMAX_KHZ  = 50;
    // Least times round up to whole cycles
    localparam int unsigned SPS_RESET_MIN_CYC  =
        (SPS_RESET_MIN_NS * 1000 + SPS_CLK_PERIOD_PS - 1) / SPS_CLK_PERIOD_PS;
    localparam int unsigned SPS_STEP_WIDTH_CYC =
        (SPS_STEP_WIDTH_NS * 1000 + SPS_CLK_PERIOD_PS - 1) / SPS_CLK_PERIOD_PS;
    localparam int unsigned SPS_DIR_HOLD_CYC   =
        (SPS_DIR_HOLD_NS * 1000 + SPS_CLK_PERIOD_PS - 1) / SPS_CLK_PERIOD_PS;
    localparam int unsigned SPS_MODE_HOLD_CYC  =
        (SPS_MODE_HOLD_NS * 1000 + SPS_CLK_PERIOD_PS - 1) / SPS_CLK_PERIOD_PS;

    // ------------------------------------------------------------
    // Sequence position and coil layout
    // ------------------------------------------------------------
    localparam int unsigned SPS_POS_W     = 3;
    localparam logic [2:0]  SPS_POS_RESET = 3'h0;
    // Coil vector: {coil_two_rev, coil_two_fwd, coil_one_rev, coil_one_fwd}
    localparam int unsigned SPS_COIL_W    = 4;
    localparam logic [3:0]  SPS_COILS_OFF = 4'h0;

    // Synchroniser lane order
    localparam int unsigned SPS_IN_STEP   = 0;
    localparam int unsigned SPS_IN_MODE   = 1;
    localparam int unsigned SPS_IN_DIR    = 2;
    localparam int unsigned SPS_IN_RUN    = 3;
    localparam int unsigned SPS_IN_EN     = 4;
    localparam int unsigned SPS_IN_W      = 5;
    // Step lane idles high so a clock already high at reset is no edge
    localparam logic [4:0]  SPS_SYNC_RESET = 5'h01;

    // ------------------------------------------------------------
    // Register map (AXI4-Lite byte addresses)
    // ------------------------------------------------------------
    localparam int unsigned SPS_ADDR_W      = 4;
    localparam logic [3:0]  SPS_ADDR_CTRL   = 4'h0;
    localparam logic [3:0]  SPS_ADDR_STATUS = 4'h4;
    localparam logic [3:0]  SPS_ADDR_STEPS  = 4'h8;
    localparam logic        SPS_CTRL_RESET  = 1'b1;
    localparam int unsigned SPS_STEPS_W     = 16;
    localparam logic [15:0] SPS_STEPS_RESET = 16'h0000;
    // STATUS field positions
    localparam int unsigned SPS_ST_POS      = 0;
    localparam int unsigned SPS_ST_MODE     = 3;
    localparam int unsigned SPS_ST_DIR      = 4;
    localparam int unsigned SPS_ST_EN       = 5;
    localparam int unsigned SPS_ST_RUN      = 6;
    localparam int unsigned SPS_ST_COILS    = 8;
    localparam logic [1:0]  SPS_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  SPS_RESP_SLVERR = 2'h2;

endpackage

// File: design/sps_ctl_if.sv
`timescale 1ns/1ps
// Synchronised control lines from the input stage to the sequencer
interface sps_ctl_if;
    logic step_rise;
    logic half_step;
    logic reverse;
    logic run;
    logic enable;

    modport src (output step_rise, output half_step, output reverse, output run, output enable);
    modport dst (input step_rise, input half_step, input reverse, input run, input enable);
endinterface

// File: design/sps_input_sync.sv
`timescale 1ns/1ps
module sps_input_sync
    import sps_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic step_clock,
    input  wire logic excitation_select,
    input  wire logic direction_select,
    input  wire logic sequencer_reset_low,
    input  wire logic output_enable,
    sps_ctl_if.src    ctl
);

    typedef struct packed {
        logic [SPS_IN_W-1:0] meta;
        logic [SPS_IN_W-1:0] sync;
        logic                step_prev;
    } sps_sync_state_t;

    sps_sync_state_t st;
    sps_sync_state_t next_st;

    // ------------------------------------------------------------
    // Two-flop synchronisers plus step history
    // ------------------------------------------------------------
    // Only the second stage is looked at; the first may be metastable
    always_comb begin
        next_st           = st;
        next_st.meta      = {output_enable, sequencer_reset_low, direction_select,
                             excitation_select, step_clock};
        next_st.sync      = st.meta;
        next_st.step_prev = st.sync[SPS_IN_STEP];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st.meta      <= SPS_SYNC_RESET;
            st.sync      <= SPS_SYNC_RESET;
            st.step_prev <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Rising step edge seen in the logic clock domain
    assign ctl.step_rise = st.sync[SPS_IN_STEP] && !st.step_prev;
    assign ctl.half_step = st.sync[SPS_IN_MODE];
    assign ctl.reverse   = st.sync[SPS_IN_DIR];
    assign ctl.run       = st.sync[SPS_IN_RUN];
    assign ctl.enable    = st.sync[SPS_IN_EN];

endmodule

// File: design/sps_phase_decode.sv
`timescale 1ns/1ps
module sps_phase_decode
    import sps_pkg::*;
(
    input  wire logic [SPS_POS_W-1:0]  pos,
    output logic      [SPS_COIL_W-1:0] coils
);

    // ------------------------------------------------------------
    // Position to coil pattern
    // ------------------------------------------------------------
    // Even positions drive two adjacent coils, odd ones a single coil,
    // so full and half stepping share one rotational order
    always_comb begin
        unique case (pos)
            3'h0: coils = 4'h9;    // One fwd + two rev, first after reset
            3'h1: coils = 4'h1;    // One fwd
            3'h2: coils = 4'h5;    // One fwd + two fwd
            3'h3: coils = 4'h4;    // Two fwd
            3'h4: coils = 4'h6;    // One rev + two fwd
            3'h5: coils = 4'h2;    // One rev
            3'h6: coils = 4'hA;    // One rev + two rev
            3'h7: coils = 4'h8;    // Two rev
        endcase
    end

endmodule

// File: design/sps_sequencer.sv
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module sps_sequencer
    import sps_pkg::*;
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // Controller pins
    input  wire logic                  step_clock,
    input  wire logic                  excitation_select,
    input  wire logic                  direction_select,
    input  wire logic                  sequencer_reset_low,
    input  wire logic                  output_enable,
    // Winding drives
    output logic                       coil_one_fwd,
    output logic                       coil_one_rev,
    output logic                       coil_two_fwd,
    output logic                       coil_two_rev,
    // AXI4-Lite slave
    input  wire logic [SPS_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]            s_axi_awprot,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [SPS_ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]            s_axi_arprot,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready
);

    typedef struct packed {
        logic [SPS_POS_W-1:0]   pos;
        logic [SPS_COIL_W-1:0]  coils;
        logic                   soft_en;
        logic [SPS_STEPS_W-1:0] steps;
        logic                   aw_rdy;
        logic                   w_rdy;
        logic                   aw_got;
        logic                   w_got;
        logic [SPS_ADDR_W-1:0]  waddr;
        logic [31:0]            wdata;
        logic [3:0]             wstrb;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   ar_rdy;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
    } sps_top_state_t;

    // One record holds all state; every output below is a bit of it
    sps_top_state_t            st;
    sps_top_state_t            next_st;
    logic [SPS_COIL_W-1:0]     table_coils;
    logic                      drive_en;
    logic                      wr_fire;
    logic                      wr_steps_clr;
    logic [31:0]               status_word;

    // Synchronised control lines from the input stage
    sps_ctl_if ctl ();

    // ------------------------------------------------------------
    // Input synchronisers and coil table
    // ------------------------------------------------------------
    // Pins reach the sequencer two cycles late; the coils follow a step two more, run or enable one more
    sps_input_sync u_sync (
        .aclk                (aclk),
        .aresetn             (aresetn),
        .step_clock          (step_clock),
        .excitation_select   (excitation_select),
        .direction_select    (direction_select),
        .sequencer_reset_low (sequencer_reset_low),
        .output_enable       (output_enable),
        .ctl                 (ctl.src)
    );

    // Coil pattern of the present position, registered once more below
    sps_phase_decode u_decode (
        .pos   (st.pos),
        .coils (table_coils)
    );

    // ------------------------------------------------------------
    // Step arithmetic
    // ------------------------------------------------------------
    // Full-step from an odd (single coil) position moves one slot onto the
    // nearest two-coil state in the travel direction, so no step is skipped
    function automatic logic [SPS_POS_W-1:0] sps_advance(
        input logic [SPS_POS_W-1:0] pos,
        input logic                 half,
        input logic                 rev
    );
        logic [SPS_POS_W-1:0] delta;
        delta = (half || pos[0]) ? 3'h1 : 3'h2;
        if (rev) begin
            sps_advance = pos - delta;
        end else begin
            sps_advance = pos + delta;
        end
    endfunction

    // Address decode shared by the write and read paths; holes answer SLVERR
    function automatic logic [1:0] sps_resp_for(
        input logic [SPS_ADDR_W-1:0] addr
    );
        unique case (addr)
            SPS_ADDR_CTRL, SPS_ADDR_STATUS, SPS_ADDR_STEPS: begin
                sps_resp_for = SPS_RESP_OKAY;
            end
            default: begin
                sps_resp_for = SPS_RESP_SLVERR;
            end
        endcase
    endfunction

    // Software enable gates the pin enable; both must be high to drive
    // The pins pass the sync stage, so the coils drop within four cycles
    assign drive_en = ctl.run && ctl.enable && st.soft_en;

    // Write happens once address and data are both held
    // An unanswered response blocks a second fire of the same write
    assign wr_fire      = st.aw_got && st.w_got && !st.bvalid;
    assign wr_steps_clr = wr_fire && (st.waddr == SPS_ADDR_STEPS) && st.wstrb[0];

    // Live status word for reads
    // Pin fields show synchronised levels, two cycles behind the pins
    always_comb begin
        status_word                                      = 32'h0000_0000;
        status_word[SPS_ST_POS +: SPS_POS_W]             = st.pos;
        status_word[SPS_ST_MODE]                         = ctl.half_step;
        status_word[SPS_ST_DIR]                          = ctl.reverse;
        status_word[SPS_ST_EN]                           = ctl.enable;
        status_word[SPS_ST_RUN]                          = ctl.run;
        status_word[SPS_ST_COILS +: SPS_COIL_W]          = st.coils;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;

        // Sequencer: reset wins, then an edge advances, otherwise hold.
        // Position keeps moving while disabled so timing carries through.
        if (!ctl.run) begin
            next_st.pos = SPS_POS_RESET;
        end else if (ctl.step_rise) begin
            next_st.pos = sps_advance(st.pos, ctl.half_step, ctl.reverse);
        end

        // Coil drive follows the table one cycle after the position
        if (drive_en) begin
            next_st.coils = table_coils;
        end else begin
            next_st.coils = SPS_COILS_OFF;
        end

        // Step counter; a step in the clearing cycle still counts
        if (wr_steps_clr) begin
            next_st.steps = SPS_STEPS_RESET;
        end
        if (ctl.run && ctl.step_rise) begin
            next_st.steps = (wr_steps_clr ? SPS_STEPS_RESET : st.steps) + 16'h0001;
        end

        // Write address and data channels, taken in either order
        if (s_axi_awvalid && st.aw_rdy) begin
            next_st.aw_got = 1'b1;
            next_st.waddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.w_rdy) begin
            next_st.w_got = 1'b1;
            next_st.wdata = s_axi_wdata;
            next_st.wstrb = s_axi_wstrb;
        end

        // Register write and response
        if (wr_fire) begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = sps_resp_for(st.waddr);
            unique case (st.waddr)
                SPS_ADDR_CTRL: begin
                    if (st.wstrb[0]) begin
                        next_st.soft_en = st.wdata[0];
                    end
                end
                SPS_ADDR_STATUS, SPS_ADDR_STEPS: begin
                    // Status ignores writes; steps clears above
                end
                default: begin
                    // Unmapped: nothing changes, the response says SLVERR
                end
            endcase
        end else if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        // Readies drop once a channel is held, so no second write slips in
        next_st.aw_rdy = !next_st.aw_got && !next_st.bvalid;
        next_st.w_rdy  = !next_st.w_got && !next_st.bvalid;

        // Read channel: data captured when the address is taken
        // A status read is a snapshot of the address cycle, not a later one
        if (s_axi_arvalid && st.ar_rdy) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = sps_resp_for(s_axi_araddr);
            unique case (s_axi_araddr)
                SPS_ADDR_CTRL: begin
                    next_st.rdata = {31'h0000_0000, st.soft_en};
                end
                SPS_ADDR_STATUS: begin
                    next_st.rdata = status_word;
                end
                SPS_ADDR_STEPS: begin
                    next_st.rdata = {16'h0000, st.steps};
                end
                default: begin
                    next_st.rdata = 32'h0000_0000;
                end
            endcase
        end else if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        next_st.ar_rdy = !next_st.rvalid;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Bus reset only; the sequencer reset pin acts through the sync stage
    // and the next-state logic, so it never disturbs a bus transfer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st.pos     <= SPS_POS_RESET;
            st.coils   <= SPS_COILS_OFF;
            st.soft_en <= SPS_CTRL_RESET;
            st.steps   <= SPS_STEPS_RESET;
            st.aw_rdy  <= 1'b1;
            st.w_rdy   <= 1'b1;
            st.aw_got  <= 1'b0;
            st.w_got   <= 1'b0;
            st.waddr   <= 4'h0;
            st.wdata   <= 32'h0000_0000;
            st.wstrb   <= 4'h0;
            st.bvalid  <= 1'b0;
            st.bresp   <= SPS_RESP_OKAY;
            st.ar_rdy  <= 1'b1;
            st.rvalid  <= 1'b0;
            st.rdata   <= 32'h0000_0000;
            st.rresp   <= SPS_RESP_OKAY;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from flops
    // ------------------------------------------------------------
    // Winding drives, one lane of the coil vector each
    assign coil_one_fwd  = st.coils[0];
    assign coil_one_rev  = st.coils[1];
    assign coil_two_fwd  = st.coils[2];
    assign coil_two_rev  = st.coils[3];

    // Bus handshakes and answers
    assign s_axi_awready = st.aw_rdy;
    assign s_axi_wready  = st.w_rdy;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = st.ar_rdy;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rdata   = st.rdata;
    assign s_axi_rresp   = st.rresp;

endmodule

// File: tb/sps_seq_monitor.sv
`timescale 1ns/1ps
module sps_seq_monitor
    import sps_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic step_clock,
    input wire logic excitation_select,
    input wire logic sequencer_reset_low,
    input wire logic output_enable,
    input wire logic coil_one_fwd,
    input wire logic coil_one_rev,
    input wire logic coil_two_fwd,
    input wire logic coil_two_rev
);
    logic [SPS_COIL_W-1:0] coils;

    // ------------------------------------------------------------
    // Drive vector
    // ------------------------------------------------------------
    // Same lane order as the package coil vector
    assign coils = {coil_two_rev, coil_two_fwd, coil_one_rev, coil_one_fwd};

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ------------------------------------------------------------
    // Drive rules
    // ------------------------------------------------------------
    // Five low samples cover the two sync stages plus the drive registers
    reset_off_a: assert property (
        !sequencer_reset_low [*5] |-> coils == SPS_COILS_OFF)
        else $error("coils driven while sequencer reset low");
    enable_off_a: assert property (
        !output_enable [*5] |-> coils == SPS_COILS_OFF)
        else $error("coils driven while output enable low");
    hold_state_a: assert property (
        ($stable(step_clock) && sequencer_reset_low && output_enable) [*8] |-> $stable(coils))
        else $error("coils moved without a step edge");
    step_moves_a: assert property (
        $rose(step_clock) && $past(aresetn, 4) && $past(sequencer_reset_low, 4)
        && $past(output_enable, 4) ##0 (sequencer_reset_low && output_enable) [*8]
        |-> coils != $past(coils, 7))
        else $error("step edge did not move the coils");
    first_state_a: assert property (
        !sequencer_reset_low ##1
        (sequencer_reset_low && output_enable && $stable(step_clock)) [*8] |-> coils == 4'h9)
        else $error("wrong first state after sequencer reset");
    half_alt_a: assert property (
        excitation_select [*8] ##0 ($changed(coils) && coils != SPS_COILS_OFF
        && $past(coils) != SPS_COILS_OFF) |-> $countones(coils) != $countones($past(coils)))
        else $error("half step did not alternate single and double");
    full_pair_a: assert property (
        !excitation_select [*8] ##0 ($changed(coils) && coils != SPS_COILS_OFF
        && $past(coils) != SPS_COILS_OFF) |-> $countones(coils) == 2)
        else $error("full step state without two coils");
    winding_legal_a: assert property (
        !(coil_one_fwd && coil_one_rev) && !(coil_two_fwd && coil_two_rev))
        else $error("both ends of one winding driven");
endmodule

bind sps_sequencer sps_seq_monitor u_mon (
    .aclk(aclk), .aresetn(aresetn), .step_clock(step_clock),
    .excitation_select(excitation_select), .sequencer_reset_low(sequencer_reset_low),
    .output_enable(output_enable), .coil_one_fwd(coil_one_fwd),
    .coil_one_rev(coil_one_rev), .coil_two_fwd(coil_two_fwd), .coil_two_rev(coil_two_rev)
);

// File: tb/sps_motor_model.sv
`timescale 1ns/1ps
// Windings: turn the four drives into a rotor index; 8 is free, F a shorted winding
module sps_motor_model (
    input wire logic       coil_one_fwd,
    input wire logic       coil_one_rev,
    input wire logic       coil_two_fwd,
    input wire logic       coil_two_rev,
    output logic     [3:0] rotor_pos
);
    // Rotation order of the eight excitation states
    always_comb begin
        case ({coil_two_rev, coil_two_fwd, coil_one_rev, coil_one_fwd})
            4'h9: rotor_pos = 4'h0;
            4'h1: rotor_pos = 4'h1;
            4'h5: rotor_pos = 4'h2;
            4'h4: rotor_pos = 4'h3;
            4'h6: rotor_pos = 4'h4;
            4'h2: rotor_pos = 4'h5;
            4'hA: rotor_pos = 4'h6;
            4'h8: rotor_pos = 4'h7;
            4'h0: rotor_pos = 4'h8;
            default: rotor_pos = 4'hF;
        endcase
    end
endmodule

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
    import sps_pkg::*;
    localparam int unsigned LIMIT = 90000;
    localparam int unsigned PH    = SPS_STEP_WIDTH_CYC;
    logic                  aclk      = 1'b0;
    logic                  aresetn   = 1'b0;
    logic                  step_clk  = 1'b0;
    logic                  half      = 1'b0;
    logic                  rev       = 1'b0;
    logic                  run       = 1'b0;
    logic                  oe        = 1'b1;
    logic [3:0]            coil;
    logic [SPS_ADDR_W-1:0] awaddr    = 4'h0;
    logic                  awvalid   = 1'b0;
    logic                  awready;
    logic [31:0]           wdata     = 32'h0;
    logic                  wvalid    = 1'b0;
    logic                  wready;
    logic [1:0]            bresp;
    logic                  bvalid;
    logic                  bready    = 1'b0;
    logic [SPS_ADDR_W-1:0] araddr    = 4'h0;
    logic                  arvalid   = 1'b0;
    logic                  arready;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic                  rvalid;
    logic                  rready    = 1'b0;
    logic [3:0]            rotor_pos;
    logic [2:0]            exp_pos   = 3'h0;
    logic [31:0]           rd;
    logic [1:0]            rsp;
    int                    err_total = 0;
    int                    samples_checked = 0;
    int                    cycles    = 0;

    always #5 aclk = ~aclk;

    sps_sequencer uut (
        .aclk(aclk), .aresetn(aresetn), .step_clock(step_clk), .excitation_select(half),
        .direction_select(rev), .sequencer_reset_low(run), .output_enable(oe),
        .coil_one_fwd(coil[0]), .coil_one_rev(coil[1]), .coil_two_fwd(coil[2]),
        .coil_two_rev(coil[3]), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    sps_motor_model motor (
        .coil_one_fwd(coil[0]), .coil_one_rev(coil[1]), .coil_two_fwd(coil[2]),
        .coil_two_rev(coil[3]), .rotor_pos(rotor_pos));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        if (err_total == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Both write channels offered together; the trailing edge avoids a double drive
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rsp = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd_reg(input logic [3:0] a);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    // Expected position: half steps by one, full steps land on the even states
    function automatic logic [2:0] nxt(input logic [2:0] p);
        logic [2:0] d;
        d = (half || p[0]) ? 3'h1 : 3'h2;
        return rev ? p - d : p + d;
    endfunction

    // Each phase at its least width, so mode and direction may change on return
    task automatic step(input int n);
        repeat (n) begin
            repeat (PH) @(posedge aclk);
            step_clk <= 1'b1;
            repeat (PH) @(posedge aclk);
            step_clk <= 1'b0;
            exp_pos = nxt(exp_pos);
            check(32'(rotor_pos), oe ? 32'(exp_pos) : 32'h8);
        end
    endtask

    // Hang guard
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            err_total++;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (SPS_RESET_MIN_CYC) @(posedge aclk);
        check(32'(rotor_pos), 32'h8);
        run <= 1'b1;
        repeat (8) @(posedge aclk);
        check(32'(rotor_pos), 32'h0);
        rd_reg(SPS_ADDR_CTRL);
        check(rd, 32'(SPS_CTRL_RESET));
        wr(SPS_ADDR_CTRL, 32'h1);
        check(32'(rsp), 32'(SPS_RESP_OKAY));
        wr(SPS_ADDR_STEPS, 32'h0);
        step(5);
        rd_reg(SPS_ADDR_STEPS);
        check(rd, 32'h5);
        rd_reg(SPS_ADDR_STATUS);
        check(32'(rd[2:0]), 32'(exp_pos));
        check(32'(rd[6:3]), 32'hC);
        check(32'(rd[11:8]), 32'h5);
        rd_reg(4'hC);
        check({rd[29:0], rsp}, 32'(SPS_RESP_SLVERR));
        wr(4'hC, 32'h0);
        check(32'(rsp), 32'(SPS_RESP_SLVERR));
        rev <= 1'b1;
        step(3);
        half <= 1'b1;
        rev  <= 1'b0;
        step(9);
        rev <= 1'b1;
        step(2);
        // Switch back to full while on a single-coil state
        half <= 1'b0;
        step(2);
        oe <= 1'b0;
        repeat (8) @(posedge aclk);
        check(32'(rotor_pos), 32'h8);
        step(2);
        oe <= 1'b1;
        repeat (8) @(posedge aclk);
        check(32'(rotor_pos), 32'(exp_pos));
        run <= 1'b0;
        repeat (8) @(posedge aclk);
        check(32'(rotor_pos), 32'h8);
        run <= 1'b1;
        exp_pos = 3'h0;
        repeat (8) @(posedge aclk);
        check(32'(rotor_pos), 32'h0);
        step(1);
        repeat (PH) @(posedge aclk);
        check(32'(rotor_pos), 32'(exp_pos));
        close_out();
    end
endmodule
